// >>> verilog/pio_defs.svh
// Register addresses, field positions, reset values and timing counts
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

// ----------------------------------------------------------------------
// Register addresses on the four address pins
// ----------------------------------------------------------------------
`define PIO_ADDR_REV_ANGLE  4'h0
`define PIO_ADDR_FWD_ANGLE  4'h4
`define PIO_ADDR_PORT_CTRL  4'hb
`define PIO_ADDR_PORT_DATA  4'hc
`define PIO_ADDR_SYS_CTRL   4'hd
`define PIO_ADDR_INT_STATUS 4'he

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PIO_SC_CLK_DIV      5
`define PIO_SC_XFM_IEN      6
`define PIO_SC_CONV_IEN     7
`define PIO_SC_LEVEL_MODE   8
`define PIO_ST_CONV         0
`define PIO_ST_XFM          1
`define PIO_ST_PORT         2
`define PIO_ST_VALID        4
`define PIO_ST_OWN_IRQ      11
`define PIO_PC_IEN_LSB      6

// ----------------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------------
`define PIO_PORT_CTRL_RST   12'h000
`define PIO_SYS_CTRL_RST    12'h000
`define PIO_PORT_OUT_RST    6'h00
`define PIO_SYS_CTRL_MASK   12'h5fb

// ----------------------------------------------------------------------
// Transformation run times in system clock cycles
// ----------------------------------------------------------------------
`define PIO_FWD_CYCLES      6'd40
`define PIO_REV_CYCLES      6'd37

`endif

// >>> verilog/pio_pkg.sv
// Types shared by the port and interrupt logic
package pio_pkg;

  // ----------------------------------------------------------------------
  // Host strobes and address as they arrive on the pins
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
  } pio_host_t;

  // ----------------------------------------------------------------------
  // Drive of the six port pins
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [5:0] o;
    logic [5:0] oe;
  } pio_pin_drv_t;

  typedef enum logic {
    PIO_TMR_IDLE,
    PIO_TMR_RUN
  } pio_tmr_state_t;

endpackage

// >>> verilog/pio_xfm_timer.sv
// Run timer that marks the end of a vector transformation
`timescale 1ns/10ps
`default_nettype none

module pio_xfm_timer
  import pio_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_ce,
  input  wire logic       i_start,
  input  wire logic [5:0] i_cycles,
  output var  logic       o_busy,
  output var  logic       o_done
);

  pio_tmr_state_t state_reg;
  logic [5:0]     cnt_reg;
  logic           done_reg;

  // ----------------------------------------------------------------------
  // Countdown; a new start restarts the run
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= PIO_TMR_IDLE;
      cnt_reg   <= 6'h00;
      done_reg  <= 1'b0;
    end else if (i_ce) begin
      done_reg <= 1'b0;
      if (i_start) begin
        state_reg <= PIO_TMR_RUN;
        cnt_reg   <= i_cycles - 6'h01;
      end else begin
        case (state_reg)
          PIO_TMR_IDLE: begin
            cnt_reg <= 6'h00;
          end
          PIO_TMR_RUN: begin
            if (cnt_reg == 6'h00) begin
              state_reg <= PIO_TMR_IDLE;
              done_reg  <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg - 6'h01;
            end
          end
          default: begin
            state_reg <= PIO_TMR_IDLE;
          end
        endcase
      end
    end
  end

  assign o_busy = (state_reg == PIO_TMR_RUN);
  assign o_done = done_reg;

endmodule

`default_nettype wire

// >>> verilog/pio_port_irq.sv
// Six-bit digital port with change interrupts and request aggregation
`timescale 1ns/10ps
`default_nettype none
`include "pio_defs.svh"

module pio_port_irq
  import pio_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_clk_en,
  input  wire pio_host_t    i_host,
  input  wire logic [11:0]  i_data,
  output var  logic [11:0]  o_data,
  output var  logic         o_data_oe,
  input  wire logic [5:0]   i_port_pin,
  output var  pio_pin_drv_t o_port_pin,
  input  wire logic         i_conv_done,
  output var  logic         o_irq_n_o,
  output var  logic         o_irq_n_oe,
  output var  logic [11:0]  o_system_control,
  output var  logic         o_sys_ce,
  output var  logic         o_xfm_busy
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // A synchronised strobe or pin bit takes a new value only once stages two and three
  // agree, which rejects a sample caught mid-transition.
  function automatic logic [8:0] settle(input logic [8:0] s2,
                                        input logic [8:0] s3,
                                        input logic [8:0] old);
    logic [8:0] agree;
    agree  = ~(s2 ^ s3);
    settle = (agree & s3) | (~agree & old);
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam int SYNC_W = 25;

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync3_reg;
  logic [8:0]        stable_reg;
  logic [8:0]        stable_next;
  logic              phase_reg;
  logic              sys_ce;
  logic              rd_act_d_reg;
  logic              cs_st;
  logic              rd_st;
  logic              wr_st;
  logic              wr_next;
  logic              rd_act;
  logic              rd_start;
  logic              wr_fire;
  logic [3:0]        wr_addr;
  logic [11:0]       wr_data;
  logic [5:0]        pin_st;
  logic [5:0]        pin_next;
  logic [11:0]       port_ctrl_reg;
  logic [11:0]       sys_ctrl_reg;
  logic [5:0]        port_out_reg;
  logic [5:0]        dir;
  logic [5:0]        pin_ien;
  logic [5:0]        pin_chg;
  logic              conv_set;
  logic              xfm_set;
  logic              port_set;
  logic              any_set;
  logic              stat_clr;
  logic              flag_conv_reg;
  logic              flag_xfm_reg;
  logic              flag_port_reg;
  logic              flag_own_reg;
  logic              valid_reg;
  logic              irq_pulse_reg;
  logic              irq_level_reg;
  logic [11:0]       rd_mux;
  logic [11:0]       data_out_reg;
  logic              data_oe_reg;
  logic              xfm_start;
  logic [5:0]        xfm_cycles;
  logic              xfm_done;

  // ----------------------------------------------------------------------
  // System clock enable
  // ----------------------------------------------------------------------
  // The halved system clock is an enable on the core clock rather than a
  // derived clock, so the design keeps one clock domain.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_reg <= 1'b0;
    end else if (i_clk_en) begin
      phase_reg <= ~phase_reg;
    end
  end

  assign sys_ce = i_clk_en &
                  (phase_reg | ~sys_ctrl_reg[`PIO_SC_CLK_DIV]);
  assign o_sys_ce = sys_ce;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_reg <= {SYNC_W{1'b1}};
      sync2_reg <= {SYNC_W{1'b1}};
      sync3_reg <= {SYNC_W{1'b1}};
    end else if (sys_ce) begin
      sync1_reg <= {i_host.addr, i_data, i_host.cs_n, i_host.rd_n,
                    i_host.wr_n, i_port_pin};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign {cs_st, rd_st, wr_st} = stable_reg[8:6];
  assign pin_st                = stable_reg[5:0];

  always_comb begin
    stable_next = {settle(sync2_reg[8:0], sync3_reg[8:0], stable_reg)};
  end

  assign wr_next  = stable_next[6];
  assign pin_next = stable_next[5:0];
  assign wr_addr  = sync3_reg[24:21];
  assign wr_data  = sync3_reg[20:9];

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stable_reg   <= 9'h1ff;
      rd_act_d_reg <= 1'b0;
    end else if (sys_ce) begin
      stable_reg   <= stable_next;
      rd_act_d_reg <= rd_act;
    end
  end

  // ----------------------------------------------------------------------
  // Host strobes
  // ----------------------------------------------------------------------
  // A write takes effect on the rising edge of the write strobe, when
  // address and data have been settled for the whole strobe.
  assign rd_act   = ~cs_st & ~rd_st;
  assign rd_start = sys_ce & rd_act & ~rd_act_d_reg;
  assign wr_fire  = sys_ce & ~cs_st & ~wr_st & wr_next;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      port_ctrl_reg <= `PIO_PORT_CTRL_RST;
    end else if (wr_fire && wr_addr == `PIO_ADDR_PORT_CTRL) begin
      port_ctrl_reg <= wr_data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sys_ctrl_reg <= `PIO_SYS_CTRL_RST;
    end else if (wr_fire && wr_addr == `PIO_ADDR_SYS_CTRL) begin
      sys_ctrl_reg <= wr_data & `PIO_SYS_CTRL_MASK;
    end
  end

  assign o_system_control = sys_ctrl_reg;

  assign dir     = port_ctrl_reg[5:0];
  assign pin_ien = port_ctrl_reg[11:`PIO_PC_IEN_LSB];

  // ----------------------------------------------------------------------
  // Port data and pin drive
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      port_out_reg <= `PIO_PORT_OUT_RST;
    end else if (wr_fire && wr_addr == `PIO_ADDR_PORT_DATA) begin
      port_out_reg <= (port_out_reg & ~dir) | (wr_data[5:0] & dir);
    end
  end

  always_comb begin
    o_port_pin.o  = port_out_reg;
    o_port_pin.oe = dir;
  end

  // ----------------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------------
  // Output pins are masked, so switching a bit to output never fires it.
  assign pin_chg  = {6{sys_ce}} & (pin_next ^ pin_st);
  assign port_set = |(pin_chg & pin_ien & ~dir);
  assign conv_set = sys_ce & i_conv_done &
                    sys_ctrl_reg[`PIO_SC_CONV_IEN];
  assign xfm_set  = sys_ce & xfm_done &
                    sys_ctrl_reg[`PIO_SC_XFM_IEN];
  assign any_set  = conv_set | xfm_set | port_set;
  assign stat_clr = rd_start & (sync3_reg[24:21] == `PIO_ADDR_INT_STATUS);

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  // The read latches the flags first; a clear then takes the same edge,
  // and an event in that cycle still sets its flag.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_conv_reg <= 1'b0;
      flag_xfm_reg  <= 1'b0;
      flag_port_reg <= 1'b0;
      flag_own_reg  <= 1'b0;
    end else begin
      flag_conv_reg <= (flag_conv_reg & ~stat_clr) | conv_set;
      flag_xfm_reg  <= (flag_xfm_reg & ~stat_clr) | xfm_set;
      flag_port_reg <= (flag_port_reg & ~stat_clr) | port_set;
      flag_own_reg  <= (flag_own_reg & ~stat_clr) | any_set;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      valid_reg <= 1'b0;
    end else if (sys_ce) begin
      if (xfm_start) begin
        valid_reg <= 1'b0;
      end else if (xfm_done) begin
        valid_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Request pin
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_pulse_reg <= 1'b0;
    end else if (sys_ce) begin
      irq_pulse_reg <= any_set;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_level_reg <= 1'b0;
    end else begin
      irq_level_reg <= (irq_level_reg & ~stat_clr) | any_set;
    end
  end

  // Open drain: the pin level is always low and only the enable moves.
  assign o_irq_n_o  = 1'b0;
  assign o_irq_n_oe = sys_ctrl_reg[`PIO_SC_LEVEL_MODE] ?
                      irq_level_reg : irq_pulse_reg;

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_comb begin
    rd_mux = 12'h000;
    case (sync3_reg[24:21])
      `PIO_ADDR_PORT_DATA: begin
        rd_mux[5:0] = (port_out_reg & dir) | (pin_st & ~dir);
      end
      `PIO_ADDR_SYS_CTRL: begin
        rd_mux = sys_ctrl_reg;
      end
      `PIO_ADDR_INT_STATUS: begin
        rd_mux[`PIO_ST_CONV]    = flag_conv_reg;
        rd_mux[`PIO_ST_XFM]     = flag_xfm_reg;
        rd_mux[`PIO_ST_PORT]    = flag_port_reg;
        rd_mux[`PIO_ST_VALID]   = valid_reg;
        rd_mux[`PIO_ST_OWN_IRQ] = flag_own_reg;
      end
      default: begin
        rd_mux = 12'h000;
      end
    endcase
  end

  // Data is frozen at the start of a read so the host sees one value
  // even though flags may clear or set during the strobe.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      data_out_reg <= 12'h000;
      data_oe_reg  <= 1'b0;
    end else if (sys_ce) begin
      data_oe_reg <= rd_act;
      if (rd_start) begin
        data_out_reg <= rd_mux;
      end
    end
  end

  assign o_data    = data_out_reg;
  assign o_data_oe = data_oe_reg;

  // ----------------------------------------------------------------------
  // Transformation run timer
  // ----------------------------------------------------------------------
  // Writing either angle starts a run; the forward and reverse runs
  // cannot overlap, so one timer serves both.
  assign xfm_start = wr_fire & ((wr_addr == `PIO_ADDR_FWD_ANGLE) |
                                (wr_addr == `PIO_ADDR_REV_ANGLE));
  assign xfm_cycles = (wr_addr == `PIO_ADDR_FWD_ANGLE) ?
                      `PIO_FWD_CYCLES : `PIO_REV_CYCLES;

  pio_xfm_timer u_timer (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_ce       (sys_ce),
    .i_start    (xfm_start),
    .i_cycles   (xfm_cycles),
    .o_busy     (o_xfm_busy),
    .o_done     (xfm_done)
  );

endmodule

`default_nettype wire

// >>> test/pio_port_irq_chk.sv
// Assertions on the ports of the port and interrupt block
`timescale 1ns/10ps
`default_nettype none

module pio_port_irq_chk
  import pio_pkg::*;
(
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  input  wire pio_host_t    i_host,
  input  wire logic         i_conv_done,
  input  wire logic         o_data_oe,
  input  wire pio_pin_drv_t o_port_pin,
  input  wire logic         o_irq_n_o,
  input  wire logic         o_irq_n_oe,
  input  wire logic [11:0]  o_system_control,
  input  wire logic         o_sys_ce,
  input  wire logic         o_xfm_busy
);
  logic [7:0] busy_cnt;

  // Counts system clock steps of one transformation run
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) busy_cnt <= 8'h00;
    else if (!o_xfm_busy) busy_cnt <= 8'h00;
    else if (o_sys_ce) busy_cnt <= busy_cnt + 8'h01;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_rd_start;
    $fell(i_host.rd_n) && !i_host.cs_n;
  endsequence

  sequence s_status_held;
    !i_host.rd_n && !i_host.cs_n && i_host.addr == 4'he;
  endsequence

  a_irq_low_only: assert property (o_irq_n_oe |-> !o_irq_n_o)
    else $error("request pin driven high");
  a_edge_one_cycle: assert property ($rose(o_irq_n_oe)
    && !o_system_control[8] && !o_system_control[5] |=> !o_irq_n_oe)
    else $error("edge request not one cycle");
  a_conv_raises: assert property (i_conv_done && o_sys_ce
    && o_system_control[7] |=> o_irq_n_oe)
    else $error("enabled conversion gave no request");
  a_level_until_read: assert property ($fell(o_irq_n_oe)
    && o_system_control[8] |-> s_status_held)
    else $error("level request released without status read");
  a_read_answer: assert property (s_rd_start |-> ##[1:12] o_data_oe)
    else $error("read not answered");
  a_input_write_drop: assert property ($changed(o_port_pin.o) |->
    ((($past(o_port_pin.o) ^ o_port_pin.o) & ~$past(o_port_pin.oe))
     == 6'h00))
    else $error("input bit output value changed");
  a_xfm_run_len: assert property ($fell(o_xfm_busy) |->
    busy_cnt == 8'h28 || busy_cnt == 8'h25)
    else $error("transformation run length wrong");
  a_xfm_flag: assert property ($fell(o_xfm_busy)
    && o_system_control[6] |-> ##[0:3] o_irq_n_oe)
    else $error("transformation end gave no request");
  a_reset_quiet: assert property ($rose(i_resetn) |->
    o_system_control == 12'h000 && o_port_pin.oe == 6'h00 && !o_irq_n_oe)
    else $error("state not cleared by reset");
  a_clk_halved: assert property (o_system_control[5]
    && o_sys_ce |=> !o_sys_ce)
    else $error("system clock not halved");
endmodule

bind pio_port_irq pio_port_irq_chk u_chk (.i_core_clk(i_core_clk),
  .i_resetn(i_resetn), .i_host(i_host), .i_conv_done(i_conv_done),
  .o_data_oe(o_data_oe), .o_port_pin(o_port_pin), .o_irq_n_o(o_irq_n_o),
  .o_irq_n_oe(o_irq_n_oe), .o_system_control(o_system_control),
  .o_sys_ce(o_sys_ce), .o_xfm_busy(o_xfm_busy));

`default_nettype wire

// >>> test/pio_host_model.sv
// Host processor model on the parallel register port
`timescale 1ns/10ps
`default_nettype none

module pio_host_model
  import pio_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic [11:0] i_data,
  input  wire logic        i_data_oe,
  output var  pio_host_t   o_host,
  output var  logic [11:0] o_data
);
  initial begin
    o_host = '{addr: 4'h0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
    o_data = 12'h000;
  end

  // Strobes and hold kept wide enough for the halved system clock
  task automatic bus_write(input logic [3:0] a, input logic [11:0] d);
    @(posedge i_core_clk);
    o_host <= '{addr: a, cs_n: 1'b0, rd_n: 1'b1, wr_n: 1'b0};
    o_data <= d;
    repeat (8) @(posedge i_core_clk);
    o_host.wr_n <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    o_host.cs_n <= 1'b1;
    repeat (10) @(posedge i_core_clk);
    // Released bus shows no stale value
    o_data <= ~d;
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [11:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    o_host <= '{addr: a, cs_n: 1'b0, rd_n: 1'b1 ^ 1'b1, wr_n: 1'b1};
    do begin
      @(posedge i_core_clk);
      n++;
    end while (i_data_oe !== 1'b1 && n < 40);
    // An unanswered read returns unknowns so the compare cannot pass
    d = (i_data_oe === 1'b1) ? i_data : 12'hxxx;
    o_host.rd_n <= 1'b1;
    o_host.cs_n <= 1'b1;
    repeat (10) @(posedge i_core_clk);
  endtask
endmodule

`default_nettype wire

// >>> test/pio_port_and_irq_logic_tb.sv
// Self-checking bench for the port and interrupt block
`timescale 1ns/10ps
`default_nettype none

module pio_port_and_irq_logic_tb
  import pio_pkg::*;
;
  logic         clk;
  logic         rst_n;
  logic         ce;
  logic         conv;
  logic [5:0]   ext;
  pio_host_t    hst;
  logic [11:0]  hdat;
  logic [11:0]  rdat;
  logic         rd_oe;
  pio_pin_drv_t drv;
  logic         irq_o;
  logic         irq_oe;
  logic [11:0]  sctl;
  logic         sce;
  logic         busy;
  int           fail_count = 0;
  int           check_count = 0;
  int           cyc = 0;
  int           n;
  wire  [5:0]   pins = (drv.oe & drv.o) | (~drv.oe & ext);
  // Open-drain request line with its pull-up
  wire          irq_line = irq_oe ? irq_o : 1'b1;

  pio_port_irq dut (.i_core_clk(clk), .i_resetn(rst_n), .i_clk_en(ce),
    .i_host(hst), .i_data(hdat), .o_data(rdat), .o_data_oe(rd_oe),
    .i_port_pin(pins), .o_port_pin(drv), .i_conv_done(conv),
    .o_irq_n_o(irq_o), .o_irq_n_oe(irq_oe), .o_system_control(sctl),
    .o_sys_ce(sce), .o_xfm_busy(busy));
  pio_host_model host (.i_core_clk(clk), .i_data(rdat), .i_data_oe(rd_oe),
    .o_host(hst), .o_data(hdat));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [11:0] m,
                    input logic [11:0] e, input string nm);
    logic [11:0] d;
    host.bus_read(a, d);
    chk(nm, e, d & m);
  endtask

  task automatic irq_cnt(input int w, output int lo);
    lo = 0;
    repeat (w) begin
      @(posedge clk);
      if (irq_line === 1'b0) lo++;
    end
  endtask

  task automatic pulse_conv();
    conv <= 1'b1;
    @(posedge clk);
    conv <= 1'b0;
  endtask

  // Starts a transformation run and counts the cycles it stays busy
  task automatic xfm_run(input logic [3:0] a, output int c);
    c = 0;
    fork
      host.bus_write(a, 12'h200);
      repeat (200) begin
        @(posedge clk);
        if (busy === 1'b1) c++;
      end
    join
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    conv = 1'b0;
    ext = 6'h2a;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("sysctl", 12'h000, sctl);
    chk("dir", 12'h000, {6'h00, drv.oe});
    rd(4'hc, 12'hfff, 12'h02a, "pdata");
    rd(4'he, 12'h807, 12'h000, "stat");
    host.bus_write(4'hb, 12'h447);
    host.bus_write(4'hc, 12'hfff);
    chk("dir", 12'h007, {6'h00, drv.oe});
    chk("pout", 12'h007, {6'h00, drv.o});
    rd(4'hc, 12'hfff, 12'h02f, "pdata");
    rd(4'he, 12'h807, 12'h000, "stat");
    ext <= ext ^ 6'h08;
    irq_cnt(30, n);
    chk("irq", 12'h000, 12'(n));
    ext <= ext ^ 6'h10;
    irq_cnt(30, n);
    chk("irq", 12'h001, 12'(n));
    rd(4'he, 12'h807, 12'h804, "stat");
    rd(4'he, 12'h807, 12'h000, "stat");
    // With the clock enable low the pin change must wait
    ce <= 1'b0;
    ext <= ext ^ 6'h10;
    irq_cnt(20, n);
    chk("irq", 12'h000, 12'(n));
    ce <= 1'b1;
    irq_cnt(20, n);
    chk("irq", 12'h001, 12'(n));
    rd(4'he, 12'h807, 12'h804, "stat");
    host.bus_write(4'hd, 12'h0c0);
    rd(4'hd, 12'hfff, 12'h0c0, "sysctl");
    pulse_conv();
    irq_cnt(30, n);
    chk("irq", 12'h001, 12'(n));
    rd(4'he, 12'h807, 12'h801, "stat");
    host.bus_write(4'hd, 12'h140);
    xfm_run(4'h4, n);
    chk("busy", 12'h028, 12'(n));
    irq_cnt(30, n);
    chk("irq", 12'h01e, 12'(n));
    rd(4'he, 12'h817, 12'h812, "stat");
    irq_cnt(5, n);
    chk("irq", 12'h000, 12'(n));
    pulse_conv();
    irq_cnt(20, n);
    chk("irq", 12'h000, 12'(n));
    rd(4'he, 12'h807, 12'h000, "stat");
    xfm_run(4'h0, n);
    chk("busy", 12'h025, 12'(n));
    rd(4'he, 12'h817, 12'h812, "stat");
    host.bus_write(4'hd, 12'h020);
    n = 0;
    repeat (10) begin
      @(posedge clk);
      if (sce === 1'b1) n++;
    end
    chk("sysce", 12'h005, 12'(n));
    rd(4'hd, 12'hfff, 12'h020, "sysctl");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("sysctl", 12'h000, sctl);
    chk("pdrv", 12'h000, {drv.oe, drv.o});
    complete_run();
  end
endmodule

`default_nettype wire
